// ---- design/bpo_defines.svh ----
// register offsets, field positions, reset values and timing counts of the bcd output port
`ifndef BPO_DEFINES_SVH
`define BPO_DEFINES_SVH

// apb byte addresses
`define BPO_ADDR_CTRL 12'h000
`define BPO_ADDR_STATUS 12'h004
`define BPO_ADDR_IRQ_STAT 12'h008
`define BPO_ADDR_IRQ_MASK 12'h00c
`define BPO_ADDR_WORD 12'h010
`define BPO_ADDR_COUNT 12'h014
`define BPO_ADDR_OVSRC 12'h018

// ctrl fields
`define BPO_CTRL_CODE_LSB 0
`define BPO_CTRL_CODE_MSB 2
`define BPO_CTRL_HOLD_BIT 3
`define BPO_CTRL_EN_BIT 4
`define BPO_CTRL_RST 32'h0000_0010

// interrupt bits
`define BPO_IRQ_UPDATE 0
`define BPO_IRQ_OVER 1
`define BPO_IRQ_HOLD 2

// refresh setting codes
`define BPO_CODE_100 3'h0
`define BPO_CODE_50 3'h1
`define BPO_CODE_20 3'h2
`define BPO_CODE_10 3'h3
`define BPO_CODE_5 3'h4
`define BPO_CODE_2 3'h5
`define BPO_CODE_1 3'h6

// strobe timing
`define BPO_PCLK_HZ 20000000
`define BPO_STROBE_US 100
`define BPO_STROBE_CYC ((`BPO_STROBE_US * (`BPO_PCLK_HZ / 1000000)))

`endif

// ---- design/bpo_pkg.sv ----
// types shared by the bcd output port modules
package bpo_pkg;

  typedef enum logic [1:0] {
    BPO_IDLE = 2'b00,
    BPO_SETUP = 2'b01,
    BPO_PULSE = 2'b11
  } bpo_strobe_state_t;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
  } bpo_sync_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic update;
  } bpo_div_t;

  typedef struct packed {
    logic [2:0] code;
    logic soft_hold;
    logic enable;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic tick_d;
    logic hold_d;
    bpo_strobe_state_t st;
    logic [10:0] cnt;
    logic [15:0] upd_count;
    logic [16:0] word;
    logic neg;
    logic zero;
    logic over;
    logic stable;
    logic [3:0] ovsrc;
    logic [16:0] bcd_pin;
    logic neg_pin;
    logic zero_pin;
    logic over_pin;
    logic stable_pin;
    logic strobe_pin;
    logic irq;
  } bpo_state_t;

endpackage

// ---- design/bpo_tick_if.sv ----
// carrier between the port core and its refresh divider
`timescale 1ns/1ns
interface bpo_tick_if;
  logic tick;
  logic [2:0] code;
  logic hold;
  logic update;

  modport div (
    input tick,
    input code,
    input hold,
    output update
  );

  modport core (
    output tick,
    output code,
    output hold,
    input update
  );
endinterface

// ---- design/bpo_sync.sv ----
// two-flop synchroniser for the three pin inputs
`timescale 1ns/1ns
module bpo_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pins in, synchronised out
  input wire logic [2:0] d,
  output logic [2:0] q
);
  bpo_pkg::bpo_sync_t s_reg;
  bpo_pkg::bpo_sync_t s_next;

  always_comb
  begin
    s_next.s1 = d;
    s_next.s2 = s_reg.s1;
  end

  // open pins idle high, so reset to high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '1;
    else
      s_reg <= s_next;
  end

  assign q = s_reg.s2;
endmodule

// ---- design/bpo_rate_div.sv ----
// divides the 100 per second sample tick down to the selected bcd refresh rate
`timescale 1ns/1ns
`include "bpo_defines.svh"
module bpo_rate_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // tick in, update out
  bpo_tick_if.div tif
);
  bpo_pkg::bpo_div_t s_reg;
  bpo_pkg::bpo_div_t s_next;

  function automatic logic [6:0] ticks_per_update(input logic [2:0] code);
    case (code)
      `BPO_CODE_50: ticks_per_update = 7'd2;
      `BPO_CODE_20: ticks_per_update = 7'd5;
      `BPO_CODE_10: ticks_per_update = 7'd10;
      `BPO_CODE_5: ticks_per_update = 7'd20;
      `BPO_CODE_2: ticks_per_update = 7'd50;
      `BPO_CODE_1: ticks_per_update = 7'd100;
      default: ticks_per_update = 7'd1;
    endcase
  endfunction

  always_comb
  begin
    s_next = s_reg;
    s_next.update = 1'b0;
    if (tif.hold)
    begin
      // preload the interval so the first tick after release refreshes at once
      s_next.cnt = ticks_per_update(tif.code) - 7'd1;
    end
    else if (tif.tick)
    begin
      // a code change mid-interval takes effect at the next boundary or earlier
      if (s_reg.cnt + 7'd1 >= ticks_per_update(tif.code))
      begin
        s_next.cnt = '0;
        s_next.update = 1'b1;
      end
      else
        s_next.cnt = s_reg.cnt + 7'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tif.update = s_reg.update;
endmodule

// ---- design/bpo_top.sv ----
// isolated parallel bcd data output port with apb control and interrupt
// How it works
// - word is four bcd digits plus 10000 bit
// - sample logic-select pin, open means inverted logic
// - negative logic: data one pulls pin low
// - stable flag updated together with each word
// - over-range is or of four conditions
// - one strobe per update, data valid before it
// - refresh rate selectable 1 to 100 per second
// - refresh derived from 100 per second sample tick
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "bpo_defines.svh"
module bpo_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // measurement from the indicator core, same clock
  input wire logic [15:0] meas_digits,
  input wire logic meas_msb,
  input wire logic meas_negative,
  input wire logic meas_zero_near,
  input wire logic meas_stable,
  input wire logic adc_minus_over,
  input wire logic adc_plus_over,
  input wire logic overflow_cond_one,
  input wire logic overflow_cond_two,
  // pins from outside, asynchronous
  input wire logic sample_tick,
  input wire logic hold_n,
  input wire logic logic_select_n,
  // output pin levels, 1 means transistor off
  output logic [16:0] bcd_pin,
  output logic negative_pin,
  output logic zero_vicinity_pin,
  output logic over_pin,
  output logic stable_pin,
  output logic strobe_pin
);
  bpo_pkg::bpo_state_t s_reg;
  bpo_pkg::bpo_state_t s_next;
  logic [2:0] pins_sync;
  logic tick_rise;
  logic hold_act;
  logic true_logic;
  logic [2:0] irq_event;
  logic [2:0] irq_clear;
  logic [31:0] rd;
  logic acc_first;
  logic acc_done;
  logic upd_take;
  logic over_now;
  bpo_tick_if tif ();

  // reset leaves every transistor off, matching negative logic with zero data
  localparam bpo_pkg::bpo_state_t rst_state = '{
    code: 3'h0,
    soft_hold: 1'b0,
    enable: 1'b1,
    irq_stat: 3'h0,
    irq_mask: 3'h0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    tick_d: 1'b1,
    hold_d: 1'b0,
    st: bpo_pkg::BPO_IDLE,
    cnt: 11'h000,
    upd_count: 16'h0000,
    word: 17'h0_0000,
    neg: 1'b0,
    zero: 1'b0,
    over: 1'b0,
    stable: 1'b0,
    ovsrc: 4'h0,
    bcd_pin: 17'h1_ffff,
    neg_pin: 1'b1,
    zero_pin: 1'b1,
    over_pin: 1'b1,
    stable_pin: 1'b1,
    strobe_pin: 1'b1,
    irq: 1'b0
  };

  bpo_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({logic_select_n, hold_n, sample_tick}),
    .q(pins_sync)
  );

  bpo_rate_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .tif(tif)
  );

  // status: busy, pulse, hold, true logic, over, stable, negative, zero
  function automatic logic [7:0] status_word(input bpo_pkg::bpo_state_t s,
                                             input logic tl,
                                             input logic ha);
    status_word = {s.zero, s.neg, s.stable, s.over, tl, ha,
                   s.st == bpo_pkg::BPO_PULSE, s.st != bpo_pkg::BPO_IDLE};
  endfunction

  // read mux; unmapped addresses read as zero
  function automatic logic [31:0] reg_read(input logic [11:0] addr,
                                           input bpo_pkg::bpo_state_t s,
                                           input logic tl,
                                           input logic ha);
    reg_read = '0;
    if (addr == `BPO_ADDR_CTRL)
    begin
      reg_read = {27'h000_0000, s.enable, s.soft_hold, s.code};
    end
    else if (addr == `BPO_ADDR_STATUS)
    begin
      reg_read = {24'h00_0000, status_word(s, tl, ha)};
    end
    else if (addr == `BPO_ADDR_IRQ_STAT)
    begin
      reg_read = {29'h0000_0000, s.irq_stat};
    end
    else if (addr == `BPO_ADDR_IRQ_MASK)
    begin
      reg_read = {29'h0000_0000, s.irq_mask};
    end
    else if (addr == `BPO_ADDR_WORD)
    begin
      reg_read = {15'h0000, s.word};
    end
    else if (addr == `BPO_ADDR_COUNT)
    begin
      reg_read = {16'h0000, s.upd_count};
    end
    else if (addr == `BPO_ADDR_OVSRC)
    begin
      reg_read = {28'h000_0000, s.ovsrc};
    end
  endfunction

  // shared by the error answer and the read data gate
  function automatic logic reg_mapped(input logic [11:0] addr);
    reg_mapped = 1'b0;
    if (addr == `BPO_ADDR_CTRL)
      reg_mapped = 1'b1;
    else if (addr == `BPO_ADDR_STATUS)
      reg_mapped = 1'b1;
    else if (addr == `BPO_ADDR_IRQ_STAT)
      reg_mapped = 1'b1;
    else if (addr == `BPO_ADDR_IRQ_MASK)
      reg_mapped = 1'b1;
    else if (addr == `BPO_ADDR_WORD)
      reg_mapped = 1'b1;
    else if (addr == `BPO_ADDR_COUNT)
      reg_mapped = 1'b1;
    else if (addr == `BPO_ADDR_OVSRC)
      reg_mapped = 1'b1;
  endfunction

  // one polarity rule for every output line, strobe included
  function automatic logic pin_map(input logic tl, input logic d);
    pin_map = tl ? d : ~d;
  endfunction

  function automatic logic [16:0] pin_word(input logic tl, input logic [16:0] d);
    pin_word = tl ? d : ~d;
  endfunction

  // shorted to common reads low and selects true logic
  assign true_logic = ~pins_sync[2];
  assign hold_act = ~pins_sync[1] | s_reg.soft_hold;
  assign tick_rise = pins_sync[0] & ~s_reg.tick_d;

  assign tif.tick = tick_rise;
  assign tif.code = s_reg.code;
  assign tif.hold = hold_act | ~s_reg.enable;

  assign rd = reg_read(paddr, s_reg, true_logic, hold_act);

  // the access phase is taken once; a write lands on the answer edge
  assign acc_first = psel & penable & ~s_reg.pready;
  assign acc_done = psel & penable & s_reg.pready;

  // a held word takes no update even if the divider fires in the same cycle
  assign upd_take = tif.update & ~hold_act;
  assign over_now = adc_minus_over | adc_plus_over | overflow_cond_one
                    | overflow_cond_two;

  always_comb
  begin
    s_next = s_reg;
    irq_event = '0;
    irq_clear = '0;
    s_next.tick_d = pins_sync[0];
    s_next.hold_d = hold_act;

    // apb: one wait state, so every output stays registered
    s_next.pready = acc_first;
    s_next.pslverr = 1'b0;
    s_next.prdata = '0;
    if (acc_first)
    begin
      s_next.pslverr = ~reg_mapped(paddr);
      if (!pwrite && reg_mapped(paddr))
      begin
        s_next.prdata = rd;
      end
    end

    // writes land at the edge where the master samples pready high
    if (acc_done && pwrite)
    begin
      if (paddr == `BPO_ADDR_CTRL)
      begin
        s_next.code = pwdata[`BPO_CTRL_CODE_MSB:`BPO_CTRL_CODE_LSB];
        s_next.soft_hold = pwdata[`BPO_CTRL_HOLD_BIT];
        s_next.enable = pwdata[`BPO_CTRL_EN_BIT];
      end
      else if (paddr == `BPO_ADDR_IRQ_STAT)
      begin
        irq_clear = pwdata[2:0];
      end
      else if (paddr == `BPO_ADDR_IRQ_MASK)
      begin
        s_next.irq_mask = pwdata[2:0];
      end
    end

    // strobe sequencer: setup cycle with strobe inactive (low in true logic, high in inverted), then the pulse
    case (s_reg.st)
      bpo_pkg::BPO_IDLE:
      begin
        s_next.cnt = '0;
      end
      bpo_pkg::BPO_SETUP:
      begin
        s_next.st = bpo_pkg::BPO_PULSE;
        s_next.cnt = '0;
      end
      bpo_pkg::BPO_PULSE:
      begin
        if (s_reg.cnt == 11'(`BPO_STROBE_CYC - 1))
        begin
          s_next.st = bpo_pkg::BPO_IDLE;
        end
        else
        begin
          s_next.cnt = s_reg.cnt + 11'd1;
        end
      end
      default:
      begin
        s_next.st = bpo_pkg::BPO_IDLE;
      end
    endcase

    // a new update cuts a running pulse short so each word gets its own edge
    if (upd_take)
    begin
      s_next.word = {meas_msb, meas_digits};
      s_next.neg = meas_negative;
      s_next.zero = meas_zero_near;
      s_next.stable = meas_stable;
      // sources are latched with the word so software can tell them apart
      s_next.ovsrc = {overflow_cond_two, overflow_cond_one,
                      adc_plus_over, adc_minus_over};
      s_next.over = over_now;
      s_next.st = bpo_pkg::BPO_SETUP;
      s_next.cnt = '0;
      s_next.upd_count = s_reg.upd_count + 16'd1;
      irq_event[`BPO_IRQ_UPDATE] = 1'b1;
      irq_event[`BPO_IRQ_OVER] = over_now & ~s_reg.over;
    end
    irq_event[`BPO_IRQ_HOLD] = hold_act & ~s_reg.hold_d;

    // set wins over a same-cycle clear
    s_next.irq_stat = (s_reg.irq_stat & ~irq_clear) | irq_event;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);

    // pin levels follow the current logic selection on every line
    s_next.bcd_pin = pin_word(true_logic, s_next.word);
    s_next.neg_pin = pin_map(true_logic, s_next.neg);
    s_next.zero_pin = pin_map(true_logic, s_next.zero);
    s_next.over_pin = pin_map(true_logic, s_next.over);
    s_next.stable_pin = pin_map(true_logic, s_next.stable);
    s_next.strobe_pin = pin_map(true_logic, s_next.st == bpo_pkg::BPO_PULSE);
  end

  // asynchronous reset loads constants only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= rst_state;
    else
      s_reg <= s_next;
  end

  // apb answer
  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;

  // interrupt
  assign irq = s_reg.irq;

  // pin levels
  assign bcd_pin = s_reg.bcd_pin;
  assign negative_pin = s_reg.neg_pin;
  assign zero_vicinity_pin = s_reg.zero_pin;
  assign over_pin = s_reg.over_pin;
  assign stable_pin = s_reg.stable_pin;
  assign strobe_pin = s_reg.strobe_pin;
endmodule

// ---- sim/bpo_asserts.sv ----
// apb and pin timing checks of the bcd output port
`timescale 1ns/1ns
module bpo_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb and pins in
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic hold_n,
  input wire logic logic_select_n,
  // pins out
  input wire logic [16:0] bcd_pin,
  input wire logic negative_pin,
  input wire logic zero_vicinity_pin,
  input wire logic over_pin,
  input wire logic stable_pin,
  input wire logic strobe_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [2:0] tl_reg;
  logic [2:0] hd_reg;
  logic [10:0] sw_reg;
  logic ok;
  logic [20:0] pins;
  // pin checks wait for the synchronised select to settle in true logic
  assign ok = tl_reg == 3'h7;
  assign pins = {bcd_pin, negative_pin, zero_vicinity_pin, stable_pin};
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tl_reg <= 3'h0;
      hd_reg <= 3'h0;
      sw_reg <= 11'h000;
    end
    else
    begin
      tl_reg <= logic_select_n ? 3'h0 : tl_reg + {2'h0, tl_reg != 3'h7};
      hd_reg <= hold_n ? 3'h0 : hd_reg + {2'h0, hd_reg != 3'h7};
      sw_reg <= strobe_pin ? sw_reg + 11'h001 : 11'h000;
    end
  end
  ready_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error response malformed");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  strobe_data_a: assert property (ok && $rose(strobe_pin) |-> $stable(pins))
    else $error("data moved at strobe edge");
  flags_strobe_a: assert property (ok && $changed({pins, over_pin}) |-> !strobe_pin ##1 strobe_pin)
    else $error("word change without following strobe");
  strobe_width_a: assert property (ok && sw_reg == 11'h7d0 |-> !strobe_pin)
    else $error("strobe pulse too long");
  hold_freeze_a: assert property (ok && hd_reg == 3'h7 |-> $stable({pins, over_pin}))
    else $error("pins moved during hold");
endmodule
bind bpo_top bpo_asserts u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata,
  .hold_n, .logic_select_n, .bcd_pin, .negative_pin, .zero_vicinity_pin, .over_pin,
  .stable_pin, .strobe_pin);

// ---- sim/bpo_reader.sv ----
// reading party that latches the parallel word at each strobe rising edge
`timescale 1ns/1ns
module bpo_reader (
  // pins from the port
  input wire logic [16:0] bcd_pin,
  input wire logic over_pin,
  input wire logic strobe_pin,
  // captured word and capture count
  output logic [17:0] word,
  output int cnt
);
  initial cnt = 0;
  always @(posedge strobe_pin)
  begin
    // no 25 ms wait after the stable end: it would outlast the run budget
    word <= {over_pin, bcd_pin};
    cnt <= cnt + 1;
  end
endmodule

// ---- sim/tb_bcd_parallel_data_output.sv ----
// self-checking bench of the bcd output port
`timescale 1ns/1ns
`include "bpo_defines.svh"
module tb_bcd_parallel_data_output;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [15:0] meas_digits = 16'h0000;
  logic meas_msb = 1'b0;
  logic meas_negative = 1'b0;
  logic meas_zero_near = 1'b0;
  logic meas_stable = 1'b0;
  logic [3:0] ov = 4'h0;
  logic sample_tick = 1'b0;
  logic hold_n = 1'b1;
  logic logic_select_n = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic [16:0] bcd_pin, w;
  logic negative_pin, zero_vicinity_pin, over_pin, stable_pin, strobe_pin;
  logic [17:0] cap;
  int ncap, t;
  int ticks = 0;
  int fail_count = 0;
  int num_checks = 0;
  int rate [8] = '{1, 2, 5, 10, 20, 50, 100, 1};
  bpo_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .meas_digits, .meas_msb, .meas_negative, .meas_zero_near, .meas_stable,
    .adc_minus_over(ov[0]), .adc_plus_over(ov[1]), .overflow_cond_one(ov[2]),
    .overflow_cond_two(ov[3]), .sample_tick, .hold_n, .logic_select_n, .bcd_pin,
    .negative_pin, .zero_vicinity_pin, .over_pin, .stable_pin, .strobe_pin);
  bpo_reader u_rd (.bcd_pin, .over_pin, .strobe_pin, .word(cap), .cnt(ncap));
  always #25 pclk = ~pclk;
  // offset so tick edges never meet a clock edge
  initial
  begin
    #7;
    forever #200 sample_tick = ~sample_tick;
  end
  always @(posedge sample_tick) ticks++;
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  // samples pready at rising edges; returns at a falling edge for settled outputs
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic wcap(input int k);
    int c;
    c = ncap + k;
    for (int n = 0; ncap < c; n++)
    begin
      if (n > 5000)
      begin
        fail_count++;
        test_done();
      end
      @(negedge pclk);
    end
  endtask
  initial
  begin
    #2_000_000;
    fail_count++;
    test_done();
  end
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `BPO_ADDR_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0010, rd);
    apb(1'b0, `BPO_ADDR_IRQ_MASK, 32'h0000_0000);
    chk("mask", 32'h0000_0000, rd);
    apb(1'b0, 12'h01c, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
    $display("test regs done");
    foreach (rate[i])
    begin
      apb(1'b1, `BPO_ADDR_CTRL, 32'h0000_0010 | i);
      wcap(2);
      t = ticks;
      wcap(1);
      chk("ticks per update", rate[i], ticks - t);
    end
    $display("test rates done");
    apb(1'b1, `BPO_ADDR_CTRL, 32'h0000_0013);
    for (int j = 0; j < 5; j++)
    begin
      @(posedge pclk);
      ov <= 4'h1 << j;
      meas_digits <= 16'h9870 | 16'(j);
      meas_msb <= j[0];
      {meas_negative, meas_zero_near, meas_stable} <= j[2:0];
      w = {j[0], 16'h9870 | 16'(j)};
      wcap(2);
      chk("word", {14'h0000, j < 4, w}, cap);
      chk("flags", j[2:0], {negative_pin, zero_vicinity_pin, stable_pin});
      apb(1'b0, `BPO_ADDR_OVSRC, 32'h0000_0000);
      chk("ovsrc", {28'h000_0000, 4'h1 << j}, rd);
    end
    $display("test word done");
    apb(1'b1, `BPO_ADDR_IRQ_MASK, 32'h0000_0001);
    chk("irq set", 1, irq);
    @(posedge pclk);
    hold_n <= 1'b0;
    repeat (100) @(negedge pclk);
    t = ncap;
    @(posedge pclk);
    meas_digits <= 16'h5050;
    apb(1'b1, `BPO_ADDR_IRQ_STAT, 32'h0000_0007);
    chk("irq cleared", 0, irq);
    // long enough for the last pulse to run its full width
    repeat (2400) @(negedge pclk);
    chk("held strobes", t, ncap);
    chk("held word", w, bcd_pin);
    @(posedge pclk);
    hold_n <= 1'b1;
    w = 17'h0_5050;
    wcap(2);
    chk("word after hold", w, cap[16:0]);
    chk("irq again", 1, irq);
    $display("test hold done");
    apb(1'b1, `BPO_ADDR_CTRL, 32'h0000_0003);
    repeat (10) @(negedge pclk);
    t = ncap;
    repeat (400) @(negedge pclk);
    chk("disabled strobes", t, ncap);
    apb(1'b0, `BPO_ADDR_WORD, 32'h0000_0000);
    chk("word reg", {15'h0000, w}, rd);
    apb(1'b1, `BPO_ADDR_CTRL, 32'h0000_001b);
    repeat (10) @(negedge pclk);
    t = ncap;
    repeat (400) @(negedge pclk);
    chk("soft held strobes", t, ncap);
    apb(1'b0, `BPO_ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_000c, rd & 32'h0000_000c);
    apb(1'b1, `BPO_ADDR_CTRL, 32'h0000_0013);
    $display("test control done");
    @(posedge pclk);
    logic_select_n <= 1'b1;
    wcap(2);
    chk("inverted word", {15'h0000, ~w}, bcd_pin);
    $display("test logic done");
    test_done();
  end
endmodule
